/* dv/touch_timing_filter_buzzer_regs_tb_top.sv */
module touch_timing_filter_buzzer_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        eventMode = 1'b0;
    logic        coordValid = 1'b0;
    logic        touchActivity = 1'b0;
    logic        commActivity = 1'b0;
    logic        timeoutDisable = 1'b0;
    logic [1:0]  haltSel = 2'h0;
    logic [7:0]  eventsRaw = 8'h00;
    logic [12:0] activeCh = 13'h0000;
    logic [12:0] padActiveCh = 13'h0000;
    logic [9:0]  coordX = 10'h000;
    logic [9:0]  coordY = 10'h000;
    logic [7:0]  q;
    wire         wrEn, rdEn, useFast_reg, buzzer_reg, avgHalt_reg, lowPowerWake_reg;
    wire         commTimeout_reg;
    wire [3:0]   byteIdx;
    wire [7:0]   regAddr, wrData, rdData_reg, eventsOut_reg;
    wire [7:0]   tuneTargetProx_reg, tuneTargetKeys_reg, countsFilter_reg;
    wire [9:0]   filtX_reg, filtY_reg;
    wire [95:0]  snapThr_reg;
    int          miscompares = 0;
    int          tests_run = 0;
    int          cyc = 0;
    logic [19:0] dflt [13] = '{20'h0A050, 20'h0A100, 20'h0A210, 20'h0B040, 20'h0B120,
        20'h0C0FF, 20'h0F018, 20'h0FB18, 20'h10001, 20'h10103, 20'h10200, 20'h1030A,
        20'h11000};

    ttf_regs #(.HALT_CYC(4), .LOWPWR_CYC(4), .TIMEOUT_CYC(4), .TONE_HALF(2)) DUT (
        .clk, .rst, .ce, .wrEn, .rdEn, .regAddr, .byteIdx, .wrData, .rdData_reg,
        .eventMode, .eventsRaw, .eventsOut_reg, .activeCh, .padActiveCh, .coordValid,
        .coordX, .coordY, .filtX_reg, .filtY_reg, .useFast_reg, .buzzer_reg, .haltSel,
        .touchActivity, .avgHalt_reg, .lowPowerWake_reg, .commActivity, .timeoutDisable,
        .commTimeout_reg, .tuneTargetProx_reg, .tuneTargetKeys_reg, .countsFilter_reg,
        .snapThr_reg
    );
    ttf_host host (.clk, .wrEn, .rdEn, .regAddr, .byteIdx, .wrData, .rdData_reg);

    // Clock and run-length guard
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            miscompares++;
            close_out();
        end
    end

    task automatic close_out;
        if (miscompares == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] i, input logic [7:0] d);
        host.xfer(1'b1, a, i, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [3:0] i);
        host.xfer(1'b0, a, i, 8'h00, q);
    endtask
    // Counts level changes of the buzzer (sel 0) or the wake pulse (sel 1)
    task automatic toggles(input int n, input logic sel, output int tg);
        logic last;
        tg = 0;
        last = sel ? lowPowerWake_reg : buzzer_reg;
        repeat (n) begin
            tick(1);
            if ((sel ? lowPowerWake_reg : buzzer_reg) !== last) tg++;
            last = sel ? lowPowerWake_reg : buzzer_reg;
        end
    endtask

    task automatic t_defaults;
        for (int k = 0; k < 13; k++) begin
            rd(dflt[k][19:12], dflt[k][11:8]);
            check(q, dflt[k][7:0]);
        end
        check(snapThr_reg, {12{8'h18}});
        check(tuneTargetProx_reg, 8'h40);
        check({tuneTargetKeys_reg, countsFilter_reg}, 16'h2001);
    endtask
    task automatic t_events;
        eventMode = 1'b1;
        eventsRaw = 8'hFF;
        tick(2);
        check(eventsOut_reg, 8'hBF);
        wr(8'h0C, 4'h0, 8'h21);
        tick(2);
        check(eventsOut_reg, 8'h21);
        eventMode = 1'b0;
        tick(2);
        check(eventsOut_reg, 8'hFF);
    endtask
    task automatic t_rw;
        for (int k = 0; k < 13; k++) begin
            wr(dflt[k][19:12], dflt[k][11:8], dflt[k][7:0] ^ 8'hA5);
            rd(dflt[k][19:12], dflt[k][11:8]);
            check(q, dflt[k][7:0] ^ 8'hA5);
        end
        check({snapThr_reg[95:88], snapThr_reg[7:0]}, 16'hBDBD);
        wr(8'h0F, 4'hC, 8'h77);
        rd(8'h0F, 4'hC);
        check(q, 8'h00);
        rd(8'h0D, 4'h0);
        check(q, 8'h00);
        // A write offered while the clock enable is low must not land
        ce = 1'b0;
        wr(8'h0C, 4'h0, 8'h00);
        ce = 1'b1;
        rd(8'h0C, 4'h0);
        check(q, 8'h5A);
    endtask
    task automatic t_bitmaps;
        logic [31:0] e;
        activeCh = 13'h1ABC;
        padActiveCh = 13'h0F35;
        e = 32'h0F35_1ABC;
        for (int k = 0; k < 4; k++) begin
            rd(8'h0E, k[3:0]);
            check(q, e[8*k+:8]);
        end
        wr(8'h0E, 4'h0, 8'h00);
        rd(8'h0E, 4'h0);
        check(q, 8'hBC);
    endtask
    task automatic t_coord;
        int cx [5] = '{100, 104, 116, 126, 113};
        logic [10:0] ef [5] = '{11'h464, 11'h064, 11'h474, 11'h075, 11'h074};
        wr(8'h10, 4'h1, 8'h03);
        wr(8'h10, 4'h2, 8'h00);
        wr(8'h10, 4'h3, 8'h0A);
        // Last sample moves backwards, so the shift must keep the sign
        for (int k = 0; k < 5; k++) begin
            coordX = cx[k][9:0];
            coordY = cx[k][9:0];
            coordValid = 1'b1;
            tick(1);
            coordValid = 1'b0;
            tick(2);
            check({useFast_reg, filtX_reg, filtY_reg}, {ef[k], ef[k][9:0]});
        end
    endtask
    task automatic t_buzz;
        int tg;
        wr(8'h11, 4'h0, 8'h84);
        tick(3);
        check(buzzer_reg, 1'b1);
        wr(8'h11, 4'h0, 8'h80);
        tick(3);
        check(buzzer_reg, 1'b0);
        wr(8'h11, 4'h0, 8'h04);
        tick(3);
        check(buzzer_reg, 1'b0);
        wr(8'h11, 4'h0, 8'h82);
        toggles(40, 1'b0, tg);
        check(tg >= 18 && tg <= 21, 1'b1);
        wr(8'h11, 4'h0, 8'h80);
        wr(8'h11, 4'h0, 8'h81);
        toggles(40, 1'b0, tg);
        check({tg >= 5 && tg <= 9, buzzer_reg}, 2'b10);
    endtask
    task automatic t_timers;
        int tg;
        haltSel = 2'h2;
        tick(4);
        check(avgHalt_reg, 1'b0);
        haltSel = 2'h3;
        tick(4);
        check(avgHalt_reg, 1'b1);
        haltSel = 2'h0;
        wr(8'h0A, 4'h0, 8'h02);
        wr(8'h0A, 4'h2, 8'h02);
        touchActivity = 1'b1;
        commActivity = 1'b1;
        tick(1);
        touchActivity = 1'b0;
        commActivity = 1'b0;
        tick(4);
        check({avgHalt_reg, commTimeout_reg}, 2'b00);
        tick(8);
        check({avgHalt_reg, commTimeout_reg}, 2'b11);
        haltSel = 2'h1;
        tick(2);
        check(avgHalt_reg, 1'b1);
        commActivity = 1'b1;
        tick(1);
        commActivity = 1'b0;
        tick(1);
        check(commTimeout_reg, 1'b0);
        wr(8'h0A, 4'h1, 8'h02);
        toggles(80, 1'b1, tg);
        check(tg >= 14 && tg <= 22, 1'b1);
    endtask

    // Reset, then the scenarios in turn
    initial begin
        tick(16);
        rst = 1'b0;
        t_defaults();
        t_events();
        t_rw();
        t_bitmaps();
        t_coord();
        t_buzz();
        t_timers();
        close_out();
    end
endmodule

/* dv/ttf_host.sv */
// Host side of the register port, one byte per request
module ttf_host (
    input  wire        clk,
    output logic       wrEn = 1'b0,
    output logic       rdEn = 1'b0,
    output logic [7:0] regAddr = 8'h00,
    output logic [3:0] byteIdx = 4'h0,
    output logic [7:0] wrData = 8'h00,
    input  wire  [7:0] rdData_reg
);
    timeunit 1ns;
    timeprecision 1ns;

    // Request held through its taking edge, then regAddr and wrData scrambled, byteIdx kept
    task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] i,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        #2;
        wrEn = w;
        rdEn = !w;
        regAddr = a;
        byteIdx = i;
        wrData = d;
        @(posedge clk);
        #2;
        wrEn = 1'b0;
        rdEn = 1'b0;
        regAddr = ~a;
        wrData = ~d;
        @(posedge clk);
        #2;
        q = rdData_reg;
    endtask
endmodule

/* dv/ttf_regs_asserts.sv */
// Watches the register bank ports against the documented behaviour
module ttf_regs_asserts #(
    parameter COORD_W = 10
) (
    input wire               clk,
    input wire               rst,
    input wire               ce,
    input wire               wrEn,
    input wire               rdEn,
    input wire [7:0]         regAddr,
    input wire [3:0]         byteIdx,
    input wire [7:0]         wrData,
    input wire [7:0]         rdData_reg,
    input wire               eventMode,
    input wire [7:0]         eventsRaw,
    input wire [7:0]         eventsOut_reg,
    input wire [12:0]        activeCh,
    input wire               coordValid,
    input wire [COORD_W-1:0] coordX,
    input wire [COORD_W-1:0] coordY,
    input wire [COORD_W-1:0] filtX_reg,
    input wire [COORD_W-1:0] filtY_reg,
    input wire               useFast_reg,
    input wire               buzzer_reg,
    input wire [1:0]         haltSel,
    input wire               avgHalt_reg,
    input wire [7:0]         tuneTargetProx_reg,
    input wire [95:0]        snapThr_reg
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    reg  [7:0]       bz_reg;
    reg  [7:0]       thr_reg;
    reg  [12:0]      prevAct_reg;
    wire [COORD_W:0] dX = {1'b0, coordX} - {1'b0, filtX_reg};
    wire [COORD_W:0] dY = {1'b0, coordY} - {1'b0, filtY_reg};
    wire [COORD_W:0] aX = dX[COORD_W] ? -dX : dX;
    wire [COORD_W:0] aY = dY[COORD_W] ? -dY : dY;
    wire             bigMove = (aX > thr_reg) || (aY > thr_reg);

    // Shadow copies of the buzzer and threshold bytes, taken from host writes
    always @(posedge clk) begin
        prevAct_reg <= activeCh;
        if (rst) begin
            bz_reg  <= 8'h00;
            thr_reg <= 8'h0A;
        end else if (ce && wrEn && regAddr == 8'h11 && byteIdx == 4'h0) begin
            bz_reg <= wrData;
        end else if (ce && wrEn && regAddr == 8'h10 && byteIdx == 4'h3) begin
            thr_reg <= wrData;
        end
    end

    sequence s_bz_off;
        !bz_reg[7] [*3];
    endsequence
    sequence s_bz_steady;
        (bz_reg[7] && bz_reg[1:0] == 2'h0 && $stable(bz_reg)) [*3];
    endsequence

    a_event_bypass: assert property (
        ce && !eventMode |=> eventsOut_reg == $past(eventsRaw))
        else $error("event output differs from raw events outside event mode");
    a_event_spare: assert property (
        ce && eventMode |=> !eventsOut_reg[6])
        else $error("unused event bit reported in event mode");
    a_buzz_off: assert property (s_bz_off |-> !buzzer_reg)
        else $error("buzzer driven while disabled");
    a_buzz_steady: assert property (s_bz_steady |-> buzzer_reg == bz_reg[2])
        else $error("steady buzzer level wrong");
    a_coord_select: assert property (
        ce && coordValid |=> useFast_reg == $past(bigMove))
        else $error("wrong filter constant chosen");
    a_active_low: assert property (
        ce && rdEn && regAddr == 8'h0E && byteIdx == 4'h0 |=> rdData_reg == prevAct_reg[7:0])
        else $error("active bitmap low byte wrong");
    a_active_high: assert property (
        ce && rdEn && regAddr == 8'h0E && byteIdx == 4'h1
        |=> rdData_reg == {3'h0, prevAct_reg[12:8]})
        else $error("active bitmap high byte wrong");
    a_halt_never: assert property ((haltSel == 2'h2) [*3] |-> !avgHalt_reg)
        else $error("halt raised with never-halt selection");
    a_halt_always: assert property ((haltSel == 2'h3) [*3] |-> avgHalt_reg)
        else $error("halt low with always-halt selection");
    a_reset_values: assert property (
        $fell(rst) |-> snapThr_reg == {12{8'h18}} && tuneTargetProx_reg == 8'h40)
        else $error("threshold or target reset value wrong");
endmodule

bind ttf_regs ttf_regs_asserts #(.COORD_W(COORD_W)) chk (
    .clk, .rst, .ce, .wrEn, .rdEn, .regAddr, .byteIdx, .wrData, .rdData_reg,
    .eventMode, .eventsRaw, .eventsOut_reg, .activeCh, .coordValid, .coordX, .coordY,
    .filtX_reg, .filtY_reg, .useFast_reg, .buzzer_reg, .haltSel, .avgHalt_reg,
    .tuneTargetProx_reg, .snapThr_reg
);

/* inc/ttf_defs.vh */
`ifndef TTF_DEFS_VH
`define TTF_DEFS_VH

// Register group addresses
`define TTF_ADDR_TIMINGS      8'h0A
`define TTF_ADDR_TARGETS      8'h0B
`define TTF_ADDR_EVMASK       8'h0C
`define TTF_ADDR_ACTIVE       8'h0E
`define TTF_ADDR_SNAP         8'h0F
`define TTF_ADDR_FILTERS      8'h10
`define TTF_ADDR_BUZZER       8'h11

// Reset values
`define TTF_RST_HALT          8'h50
`define TTF_RST_LOWPOWER      8'h00
`define TTF_RST_TIMEOUT       8'h10
`define TTF_RST_TGT_PROX      8'h40
`define TTF_RST_TGT_KEYS      8'h20
`define TTF_RST_EVMASK        8'hFF
`define TTF_RST_SNAP          8'h18
`define TTF_RST_CNT_FILT      8'h01
`define TTF_RST_SLOW          8'h03
`define TTF_RST_FAST          8'h00
`define TTF_RST_XY_THR        8'h0A
`define TTF_RST_BUZZER        8'h00

// Buzzer control bit positions
`define TTF_BZ_ENABLE         7
`define TTF_BZ_STEADY         2
`define TTF_BZ_PERM           1
`define TTF_BZ_BURST          0

// Halt selection codes
`define TTF_HALT_NEVER        2'h2
`define TTF_HALT_ALWAYS       2'h3

// Event mask bit that has no event behind it
`define TTF_EV_UNUSED         6

// Timing: clock period and step lengths in ns
`define TTF_CLK_PERIOD_NS     50
`define TTF_HALT_STEP_NS      250000000
`define TTF_LOWPWR_STEP_NS    16000000
`define TTF_TIMEOUT_STEP_NS   1280000
`define TTF_HALT_STEP_CYC     (`TTF_HALT_STEP_NS / `TTF_CLK_PERIOD_NS)
`define TTF_LOWPWR_STEP_CYC   (`TTF_LOWPWR_STEP_NS / `TTF_CLK_PERIOD_NS)
`define TTF_TIMEOUT_STEP_CYC  (`TTF_TIMEOUT_STEP_NS / `TTF_CLK_PERIOD_NS)

`endif

/* src/ttf_regs.v */
`include "ttf_defs.vh"

// Counts whole steps of STEP_CYC cycles after a restart; done stays high at the step count
module ttf_step_timer #(
    parameter STEP_CYC = 1000
) (
    input  wire       clk,
    input  wire       rst,
    input  wire       ce,
    input  wire       restart,
    input  wire [7:0] steps,
    output reg        done_reg
);
    reg [31:0] preCnt_reg;
    reg [7:0]  stepCnt_reg;

    // Prescaler and step counter, both cleared by restart
    always @(posedge clk) begin
        if (rst || (ce && restart)) begin
            preCnt_reg  <= 32'h0000_0000;
            stepCnt_reg <= 8'h00;
            done_reg    <= 1'b0;
        end else if (ce) begin
            done_reg <= (stepCnt_reg >= steps);
            if (stepCnt_reg < steps) begin
                if (preCnt_reg == STEP_CYC - 1) begin
                    preCnt_reg  <= 32'h0000_0000;
                    stepCnt_reg <= stepCnt_reg + 8'h01;
                end else begin
                    preCnt_reg <= preCnt_reg + 32'h0000_0001;
                end
            end
        end
    end
endmodule

module ttf_regs #(
    parameter COORD_W      = 10,
    parameter HALT_CYC     = `TTF_HALT_STEP_CYC,
    parameter LOWPWR_CYC   = `TTF_LOWPWR_STEP_CYC,
    parameter TIMEOUT_CYC  = `TTF_TIMEOUT_STEP_CYC,
    parameter TONE_HALF    = 2500,
    parameter BURST_HALVES = 8
) (
    input  wire               clk,
    input  wire               rst,
    input  wire               ce,
    input  wire               wrEn,
    input  wire               rdEn,
    input  wire [7:0]         regAddr,
    input  wire [3:0]         byteIdx,
    input  wire [7:0]         wrData,
    output reg  [7:0]         rdData_reg,
    input  wire               eventMode,
    input  wire [7:0]         eventsRaw,
    output reg  [7:0]         eventsOut_reg,
    input  wire [12:0]        activeCh,
    input  wire [12:0]        padActiveCh,
    input  wire               coordValid,
    input  wire [COORD_W-1:0] coordX,
    input  wire [COORD_W-1:0] coordY,
    output reg  [COORD_W-1:0] filtX_reg,
    output reg  [COORD_W-1:0] filtY_reg,
    output reg                useFast_reg,
    output reg                buzzer_reg,
    input  wire [1:0]         haltSel,
    input  wire               touchActivity,
    output reg                avgHalt_reg,
    output reg                lowPowerWake_reg,
    input  wire               commActivity,
    input  wire               timeoutDisable,
    output reg                commTimeout_reg,
    output reg  [7:0]         tuneTargetProx_reg,
    output reg  [7:0]         tuneTargetKeys_reg,
    output reg  [7:0]         countsFilter_reg,
    output reg  [95:0]        snapThr_reg
);
    reg  [7:0]  haltPeriod_reg;
    reg  [7:0]  lowPowerInterval_reg;
    reg  [7:0]  commTimeoutPeriod_reg;
    reg  [7:0]  eventMask_reg;
    reg  [7:0]  coordSlow_reg;
    reg  [7:0]  coordFast_reg;
    reg  [7:0]  coordThr_reg;
    reg  [7:0]  buzzerControl_reg;
    reg  [31:0] toneCnt_reg;
    reg         tone_reg;
    reg  [7:0]  burstLeft_reg;
    reg         burstPrev_reg;
    reg  [7:0]  rd_next;
    wire        haltDone;
    wire        lowPowerDone;
    wire        toDone;
    wire        lowPowerRestart;
    wire        toneEdge;
    wire signed [COORD_W:0] dX;
    wire signed [COORD_W:0] dY;
    wire        [COORD_W:0] absX;
    wire        [COORD_W:0] absY;
    wire                    fastSel;
    wire        [7:0]       beta;
    wire signed [COORD_W:0] stepX;
    wire signed [COORD_W:0] stepY;
    integer i;

    // Burst length in tone half-periods, cut to the counter width
    localparam [7:0] BURST_LOAD = BURST_HALVES[7:0];

    // Configuration writes; bitmaps have no write path
    always @(posedge clk) begin
        if (rst) begin
            haltPeriod_reg        <= `TTF_RST_HALT;
            lowPowerInterval_reg  <= `TTF_RST_LOWPOWER;
            commTimeoutPeriod_reg <= `TTF_RST_TIMEOUT;
            tuneTargetProx_reg    <= `TTF_RST_TGT_PROX;
            tuneTargetKeys_reg    <= `TTF_RST_TGT_KEYS;
            eventMask_reg         <= `TTF_RST_EVMASK;
            countsFilter_reg      <= `TTF_RST_CNT_FILT;
            coordSlow_reg         <= `TTF_RST_SLOW;
            coordFast_reg         <= `TTF_RST_FAST;
            coordThr_reg          <= `TTF_RST_XY_THR;
            buzzerControl_reg     <= `TTF_RST_BUZZER;
            for (i = 0; i < 12; i = i + 1) begin
                snapThr_reg[i*8 +: 8] <= `TTF_RST_SNAP;
            end
        end else if (ce && wrEn) begin
            if (regAddr == `TTF_ADDR_TIMINGS) begin
                if (byteIdx == 4'h0) haltPeriod_reg <= wrData;
                if (byteIdx == 4'h1) lowPowerInterval_reg <= wrData;
                if (byteIdx == 4'h2) commTimeoutPeriod_reg <= wrData;
            end else if (regAddr == `TTF_ADDR_TARGETS) begin
                if (byteIdx == 4'h0) tuneTargetProx_reg <= wrData;
                if (byteIdx == 4'h1) tuneTargetKeys_reg <= wrData;
            end else if (regAddr == `TTF_ADDR_EVMASK) begin
                if (byteIdx == 4'h0) eventMask_reg <= wrData;
            end else if (regAddr == `TTF_ADDR_SNAP) begin
                if (byteIdx < 4'hC) snapThr_reg[byteIdx*8 +: 8] <= wrData;
            end else if (regAddr == `TTF_ADDR_FILTERS) begin
                if (byteIdx == 4'h0) countsFilter_reg <= wrData;
                if (byteIdx == 4'h1) coordSlow_reg <= wrData;
                if (byteIdx == 4'h2) coordFast_reg <= wrData;
                if (byteIdx == 4'h3) coordThr_reg <= wrData;
            end else if (regAddr == `TTF_ADDR_BUZZER) begin
                if (byteIdx == 4'h0) buzzerControl_reg <= wrData;
            end
        end
    end

    // Read multiplexer; unmapped bytes read zero
    always @* begin
        rd_next = 8'h00;
        if (regAddr == `TTF_ADDR_TIMINGS) begin
            if (byteIdx == 4'h0) rd_next = haltPeriod_reg;
            if (byteIdx == 4'h1) rd_next = lowPowerInterval_reg;
            if (byteIdx == 4'h2) rd_next = commTimeoutPeriod_reg;
        end else if (regAddr == `TTF_ADDR_TARGETS) begin
            if (byteIdx == 4'h0) rd_next = tuneTargetProx_reg;
            if (byteIdx == 4'h1) rd_next = tuneTargetKeys_reg;
        end else if (regAddr == `TTF_ADDR_EVMASK) begin
            if (byteIdx == 4'h0) rd_next = eventMask_reg;
        end else if (regAddr == `TTF_ADDR_ACTIVE) begin
            if (byteIdx == 4'h0) rd_next = activeCh[7:0];
            if (byteIdx == 4'h1) rd_next = {3'h0, activeCh[12:8]};
            if (byteIdx == 4'h2) rd_next = padActiveCh[7:0];
            if (byteIdx == 4'h3) rd_next = {3'h0, padActiveCh[12:8]};
        end else if (regAddr == `TTF_ADDR_SNAP) begin
            if (byteIdx < 4'hC) rd_next = snapThr_reg[byteIdx*8 +: 8];
        end else if (regAddr == `TTF_ADDR_FILTERS) begin
            if (byteIdx == 4'h0) rd_next = countsFilter_reg;
            if (byteIdx == 4'h1) rd_next = coordSlow_reg;
            if (byteIdx == 4'h2) rd_next = coordFast_reg;
            if (byteIdx == 4'h3) rd_next = coordThr_reg;
        end else if (regAddr == `TTF_ADDR_BUZZER) begin
            if (byteIdx == 4'h0) rd_next = buzzerControl_reg;
        end
    end

    // Read data is captured on the read strobe
    always @(posedge clk) begin
        if (rst) begin
            rdData_reg <= 8'h00;
        end else if (ce && rdEn) begin
            rdData_reg <= rd_next;
        end
    end

    // Event gating; in event mode the unused mask bit never passes an event, outside it raw events pass through
    always @(posedge clk) begin
        if (rst) begin
            eventsOut_reg <= 8'h00;
        end else if (ce) begin
            if (eventMode) begin
                eventsOut_reg <= eventsRaw & eventMask_reg & ~(8'h01 << `TTF_EV_UNUSED);
            end else begin
                eventsOut_reg <= eventsRaw;
            end
        end
    end

    // Coordinate change and constant selection
    assign dX      = $signed({1'b0, coordX}) - $signed({1'b0, filtX_reg});
    assign dY      = $signed({1'b0, coordY}) - $signed({1'b0, filtY_reg});
    assign absX    = dX[COORD_W] ? (~dX + 1'b1) : dX;
    assign absY    = dY[COORD_W] ? (~dY + 1'b1) : dY;
    assign fastSel = (absX > coordThr_reg) || (absY > coordThr_reg);
    assign beta    = fastSel ? coordFast_reg : coordSlow_reg;
    assign stepX   = (beta >= COORD_W) ? $signed({(COORD_W+1){1'b0}}) : (dX >>> beta);
    assign stepY   = (beta >= COORD_W) ? $signed({(COORD_W+1){1'b0}}) : (dY >>> beta);

    // Filtered coordinates move by the change shifted down by the constant
    always @(posedge clk) begin
        if (rst) begin
            filtX_reg   <= {COORD_W{1'b0}};
            filtY_reg   <= {COORD_W{1'b0}};
            useFast_reg <= 1'b0;
        end else if (ce && coordValid) begin
            filtX_reg   <= filtX_reg + stepX[COORD_W-1:0];
            filtY_reg   <= filtY_reg + stepY[COORD_W-1:0];
            useFast_reg <= fastSel;
        end
    end

    // Tone generator for permanent and burst sounding
    assign toneEdge = (toneCnt_reg == TONE_HALF - 1);
    always @(posedge clk) begin
        if (rst) begin
            toneCnt_reg   <= 32'h0000_0000;
            tone_reg      <= 1'b0;
            burstLeft_reg <= 8'h00;
            burstPrev_reg <= 1'b0;
        end else if (ce) begin
            toneCnt_reg   <= toneEdge ? 32'h0000_0000 : toneCnt_reg + 32'h0000_0001;
            tone_reg      <= toneEdge ? ~tone_reg : tone_reg;
            burstPrev_reg <= buzzerControl_reg[`TTF_BZ_BURST];
            if (!buzzerControl_reg[`TTF_BZ_BURST]) begin
                burstLeft_reg <= 8'h00;
            end else if (!burstPrev_reg) begin
                burstLeft_reg <= BURST_LOAD;
            end else if (toneEdge && burstLeft_reg != 8'h00) begin
                burstLeft_reg <= burstLeft_reg - 8'h01;
            end
        end
    end

    // Buzzer pin: permanent tone, then burst, then steady level
    always @(posedge clk) begin
        if (rst) begin
            buzzer_reg <= 1'b0;
        end else if (ce) begin
            if (!buzzerControl_reg[`TTF_BZ_ENABLE]) begin
                buzzer_reg <= 1'b0;
            end else if (buzzerControl_reg[`TTF_BZ_PERM]) begin
                buzzer_reg <= tone_reg;
            end else if (buzzerControl_reg[`TTF_BZ_BURST]) begin
                buzzer_reg <= (burstLeft_reg != 8'h00) & tone_reg;
            end else begin
                buzzer_reg <= buzzerControl_reg[`TTF_BZ_STEADY];
            end
        end
    end

    // Halt timer restarts on touch activity
    ttf_step_timer #(.STEP_CYC(HALT_CYC)) uHalt (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .restart  (touchActivity),
        .steps    (haltPeriod_reg),
        .done_reg (haltDone)
    );

    // Low-power interval restarts itself each time it elapses
    assign lowPowerRestart = lowPowerDone | (lowPowerInterval_reg == 8'h00);
    ttf_step_timer #(.STEP_CYC(LOWPWR_CYC)) uLowPower (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .restart  (lowPowerRestart),
        .steps    (lowPowerInterval_reg),
        .done_reg (lowPowerDone)
    );

    // Communication timeout restarts on bus activity
    ttf_step_timer #(.STEP_CYC(TIMEOUT_CYC)) uTimeout (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .restart  (commActivity | timeoutDisable),
        .steps    (commTimeoutPeriod_reg),
        .done_reg (toDone)
    );

    // Timer outputs
    always @(posedge clk) begin
        if (rst) begin
            avgHalt_reg      <= 1'b0;
            lowPowerWake_reg <= 1'b0;
            commTimeout_reg  <= 1'b0;
        end else if (ce) begin
            if (haltSel == `TTF_HALT_NEVER) begin
                avgHalt_reg <= 1'b0;
            end else if (haltSel == `TTF_HALT_ALWAYS) begin
                avgHalt_reg <= 1'b1;
            end else begin
                avgHalt_reg <= haltDone;
            end
            lowPowerWake_reg <= lowPowerDone;
            commTimeout_reg  <= toDone & ~timeoutDisable;
        end
    end
endmodule
